// ### verilog/cig_params.svh
// offsets, field positions, reset values and timing counts of the gating block
`ifndef CIG_PARAMS_SVH
`define CIG_PARAMS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define CIG_IDX_ICR 14'h0001
`define CIG_IDX_IDLE_STATUS_REG 14'h0002
`define CIG_IDX_INT_FLAG_REG_0 14'h0010
`define CIG_IDX_INT_FLAG_REG_1 14'h0011
`define CIG_IDX_INT_ENABLE_REG_0 14'h0012
`define CIG_IDX_INT_ENABLE_REG_1 14'h0013
`define CIG_IDX_PCG1 14'h1C02
`define CIG_IDX_PCG2 14'h1C03

// ************************************************************
// reset values and field layout
// ************************************************************
`define CIG_REG_RST 16'h0000
`define CIG_IDLE_STATUS_REG_MASK 16'h01E1
`define CIG_PCG1_RO_MASK 16'h0020
`define CIG_IDLE_CFG_OK 4'hF
`define CIG_BUS_ERROR_FLAG_BIT 7
`define CIG_SYSOFF_BIT 15
`define CIG_NUM_PGATE 15

// ************************************************************
// timing and bus answers
// ************************************************************
`define CIG_PCG_MAX_CYC 6
`define CIG_PCG_SYNC 2
`define CIG_RESP_OKAY 2'h0
`define CIG_RESP_SLVERR 2'h2

`endif

// ### verilog/cig_pkg.sv
// types shared by the idle and peripheral clock gating block
package cig_pkg;

  // idle configuration / status image
  typedef struct packed {
    logic [6:0] rsvd;
    logic instr_port_idle_req;
    logic mem_port_idle_req;
    logic io_port_idle_req;
    logic data_port_idle_req;
    logic [3:0] idle_cfg_field;
    logic cpu_idle_req;
  } cig_idle_s;

  typedef enum logic [3:0] {
    SEL_ICR, SEL_IDLE_STATUS_REG, SEL_INT_FLAG_REG_0, SEL_INT_FLAG_REG_1, SEL_INT_ENABLE_REG_0, SEL_INT_ENABLE_REG_1,
    SEL_PCG1, SEL_PCG2, SEL_NONE
  } cig_sel_e;

endpackage

// ### verilog/cig_clk_gate.sv
// glitch-free clock gate: enable latched while the clock is low
`timescale 1ns/1ps
module cig_clk_gate (
  input wire logic clk, // free running clock
  input wire logic en, // high lets the clock through
  output logic gclk // gated clock
);
  logic en_l;

  // latch is closed while clk is high, so no pulse is ever shortened
  always_latch begin
    if (!clk) begin
      en_l = en;
    end
  end

  assign gclk = clk & en_l;
endmodule

// ### verilog/cig_gating.sv
// idle configuration check and peripheral clock gating with axi4-lite regs
`timescale 1ns/1ps
`include "cig_params.svh"
module cig_gating #(
  parameter int SYNC_STAGES = `CIG_PCG_SYNC // gate bit pipeline depth
) (
  input wire logic aclk, // system clock, 40 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [15:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [15:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic idle_exec, // one-cycle pulse: idle instruction executes
  input wire logic [15:0] int_evt0, // interrupt events, flag register 0
  input wire logic [15:0] int_evt1, // interrupt events, flag register 1
  input wire logic wake_pin, // wake-up pin, high re-enables system clock
  output logic int_pending, // enabled interrupt flag pending
  output cig_pkg::cig_idle_s idle_status, // idle status image
  output logic cpu_clk_g, // gated cpu clock
  output logic data_port_clk_g, // gated data port clock
  output logic io_port_clk_g, // gated io port clock
  output logic mem_port_clk_g, // gated memory port clock
  output logic instr_port_clk_g, // gated instruction port clock
  output logic [14:0] periph_clk_g, // gated peripheral clocks
  output logic sys_clk_g // gated system clock
);
  import cig_pkg::*;

  localparam int NG = 6 + `CIG_NUM_PGATE;

  if (SYNC_STAGES < 1 || SYNC_STAGES + 1 > `CIG_PCG_MAX_CYC) begin : g_chk
    $error("SYNC_STAGES too large for the gate latency");
  end

  // ************************************************************
  // functions
  // ************************************************************
  function automatic cig_sel_e reg_sel(input logic [15:0] addr);
    case (addr[15:2])
      `CIG_IDX_ICR: return SEL_ICR;
      `CIG_IDX_IDLE_STATUS_REG: return SEL_IDLE_STATUS_REG;
      `CIG_IDX_INT_FLAG_REG_0: return SEL_INT_FLAG_REG_0;
      `CIG_IDX_INT_FLAG_REG_1: return SEL_INT_FLAG_REG_1;
      `CIG_IDX_INT_ENABLE_REG_0: return SEL_INT_ENABLE_REG_0;
      `CIG_IDX_INT_ENABLE_REG_1: return SEL_INT_ENABLE_REG_1;
      `CIG_IDX_PCG1: return SEL_PCG1;
      `CIG_IDX_PCG2: return SEL_PCG2;
      default: return SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic idle_cfg_ok(input cig_idle_s c);
    logic ok;
    ok = 1'b1;
    if ((c.data_port_idle_req | c.io_port_idle_req | c.instr_port_idle_req
        | c.mem_port_idle_req) && c.idle_cfg_field != `CIG_IDLE_CFG_OK) begin
      ok = 1'b0;
    end
    if ((c.data_port_idle_req | c.io_port_idle_req | c.instr_port_idle_req)
        && !c.cpu_idle_req) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ************************************************************
  // axi4-lite write and read channels
  // ************************************************************
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [15:0] aw_addr_q, wd_q;
  logic [3:0] strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  cig_sel_e wr_sel;
  logic [15:0] wmask;
  logic [15:0] icr_q, idle_status_reg_q, int_flag_reg_0_q, int_flag_reg_1_q, int_enable_reg_0_q, int_enable_reg_1_q;
  logic [15:0] pcg1_q, pcg1_d, pcg2_q;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel = reg_sel(aw_addr_q);
  assign wmask = wr_fire ? lane_mask(strb_q) : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 16'h0000;
    end else if (s_axi_awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wd_q <= 16'h0000;
      strb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      wd_q <= s_axi_wdata[15:0];
      strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CIG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == SEL_NONE) ? `CIG_RESP_SLVERR : `CIG_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `CIG_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `CIG_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        SEL_ICR: rdata_q <= {16'h0000, icr_q};
        SEL_IDLE_STATUS_REG: rdata_q <= {16'h0000, idle_status_reg_q};
        SEL_INT_FLAG_REG_0: rdata_q <= {16'h0000, int_flag_reg_0_q};
        SEL_INT_FLAG_REG_1: rdata_q <= {16'h0000, int_flag_reg_1_q};
        SEL_INT_ENABLE_REG_0: rdata_q <= {16'h0000, int_enable_reg_0_q};
        SEL_INT_ENABLE_REG_1: rdata_q <= {16'h0000, int_enable_reg_1_q};
        SEL_PCG1: rdata_q <= {16'h0000, pcg1_q};
        SEL_PCG2: rdata_q <= {16'h0000, pcg2_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `CIG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ************************************************************
  // idle configuration, status and interrupt flags
  // ************************************************************
  logic idle_ok, bus_error_flag_set, wake_evt;

  assign idle_ok = idle_cfg_ok(cig_idle_s'(icr_q));
  assign bus_error_flag_set = idle_exec && !idle_ok;
  assign wake_evt = |((int_flag_reg_0_q & int_enable_reg_0_q) | (int_flag_reg_1_q & int_enable_reg_1_q));
  assign int_pending = wake_evt;
  assign idle_status = cig_idle_s'(idle_status_reg_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icr_q <= `CIG_REG_RST;
    end else if (wr_sel == SEL_ICR) begin
      icr_q <= (icr_q & ~wmask) | (wd_q & wmask);
    end
  end

  // valid idle copies config and wins in the same cycle; otherwise an enabled interrupt clears every idle status bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_status_reg_q <= `CIG_REG_RST;
    end else if (idle_exec && idle_ok) begin
      idle_status_reg_q <= icr_q & `CIG_IDLE_STATUS_REG_MASK;
    end else if (wake_evt) begin
      idle_status_reg_q <= `CIG_REG_RST;
    end
  end

  // set wins over a one-written clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_flag_reg_0_q <= `CIG_REG_RST;
    end else begin
      int_flag_reg_0_q <= (int_flag_reg_0_q & ~((wr_sel == SEL_INT_FLAG_REG_0) ? wd_q & wmask : 16'h0000))
        | int_evt0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_flag_reg_1_q <= `CIG_REG_RST;
    end else begin
      int_flag_reg_1_q <= (int_flag_reg_1_q & ~((wr_sel == SEL_INT_FLAG_REG_1) ? wd_q & wmask : 16'h0000))
        | int_evt1 | (16'(bus_error_flag_set) << `CIG_BUS_ERROR_FLAG_BIT);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_enable_reg_0_q <= `CIG_REG_RST;
      int_enable_reg_1_q <= `CIG_REG_RST;
    end else begin
      if (wr_sel == SEL_INT_ENABLE_REG_0) begin
        int_enable_reg_0_q <= (int_enable_reg_0_q & ~wmask) | (wd_q & wmask);
      end
      if (wr_sel == SEL_INT_ENABLE_REG_1) begin
        int_enable_reg_1_q <= (int_enable_reg_1_q & ~wmask) | (wd_q & wmask);
      end
    end
  end

  // ************************************************************
  // peripheral gating registers
  // ************************************************************
  always_comb begin
    pcg1_d = pcg1_q;
    if (wr_sel == SEL_PCG1) begin
      pcg1_d = (pcg1_q & ~wmask) | (wd_q & wmask);
    end
    pcg1_d = pcg1_d & ~`CIG_PCG1_RO_MASK;
    if (wake_pin) begin
      pcg1_d[`CIG_SYSOFF_BIT] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcg1_q <= `CIG_REG_RST;
      pcg2_q <= `CIG_REG_RST;
    end else begin
      pcg1_q <= pcg1_d;
      if (wr_sel == SEL_PCG2) begin
        pcg2_q <= (pcg2_q & ~wmask) | (wd_q & wmask);
      end
    end
  end

  // short pipeline eases timing to the far gate cells
  logic [15:0] pipe_q [SYNC_STAGES];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        pipe_q[i] <= `CIG_REG_RST;
      end
    end else begin
      pipe_q[0] <= pcg1_q;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // ************************************************************
  // gate enables and gate cells
  // ************************************************************
  logic sys_on;
  logic [NG-1:0] gate_en, gclk;

  assign sys_on = !(pcg1_q[`CIG_SYSOFF_BIT] && !wake_pin);
  assign gate_en[0] = sys_on && !idle_status_reg_q[0];
  assign gate_en[1] = sys_on && !idle_status_reg_q[5];
  assign gate_en[2] = sys_on && !idle_status_reg_q[6];
  assign gate_en[3] = sys_on && !idle_status_reg_q[7];
  assign gate_en[4] = sys_on && !idle_status_reg_q[8];
  assign gate_en[5] = sys_on;
  // peripheral register bits are plain except read-only zero bit 5; a stopped clock keeps state
  assign gate_en[NG-1:6] =
    {15{sys_on}} & ~pipe_q[SYNC_STAGES-1][14:0];

  for (genvar g = 0; g < NG; g++) begin : g_gate
    cig_clk_gate u_gate (
      .clk(aclk),
      .en(gate_en[g]),
      .gclk(gclk[g])
    );
  end

  assign cpu_clk_g = gclk[0];
  assign data_port_clk_g = gclk[1];
  assign io_port_clk_g = gclk[2];
  assign mem_port_clk_g = gclk[3];
  assign instr_port_clk_g = gclk[4];
  assign sys_clk_g = gclk[5];
  assign periph_clk_g = gclk[NG-1:6];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bus_error_flag_cfg_field: assert property (idle_exec && icr_q[8:5] != 4'h0
    && icr_q[4:1] != `CIG_IDLE_CFG_OK |=> int_flag_reg_1_q[`CIG_BUS_ERROR_FLAG_BIT]
    && (idle_status_reg_q == $past(idle_status_reg_q) || $past(wake_evt)))
    else $error("bad idle field did not raise bus error");
  a_bus_error_flag_no_cpu: assert property (idle_exec && !icr_q[0]
    && (icr_q[5] || icr_q[6] || icr_q[8]) && !wake_evt
    |=> int_flag_reg_1_q[`CIG_BUS_ERROR_FLAG_BIT] && $stable(idle_status_reg_q))
    else $error("port idle without cpu idle not refused");
  a_bus_error_flag_flag_bit: assert property ($rose(int_flag_reg_1_q[`CIG_BUS_ERROR_FLAG_BIT])
    |-> $past(idle_exec) || $past(int_evt1[`CIG_BUS_ERROR_FLAG_BIT]))
    else $error("bus error flag set without cause");
  a_io_needs_cpu: assert property (idle_status_reg_q[6] |-> idle_status_reg_q[0]
    && !gate_en[2] && !gate_en[0])
    else $error("io port idled without cpu idle");
  a_flag_clear: assert property (wr_fire && wr_sel == SEL_INT_FLAG_REG_0
    && strb_q[1:0] == 2'h3 && wd_q == 16'hFFFF && int_evt0 == 16'h0000
    |=> int_flag_reg_0_q == 16'h0000)
    else $error("ones written did not clear flags");
  a_status_copy: assert property (idle_exec && idle_ok
    |=> idle_status_reg_q == ($past(icr_q) & `CIG_IDLE_STATUS_REG_MASK) ##1 gate_en[0] == !idle_status_reg_q[0])
    else $error("idle status not copied from config");
  a_gate_latency: assert property ($rose(pcg1_q[0])
    ##1 pcg1_q[0] [*5] |-> !gate_en[6])
    else $error("peripheral gate slower than six cycles");
  a_gate_runs: assert property ((!pcg1_q[3]) [*6] ##0 sys_on
    |-> gate_en[9])
    else $error("cleared gate bit does not run clock");
  a_reserved_bit: assert property (pcg1_q[5] == 1'b0
    && idle_status_reg_q[4:1] == 4'h0)
    else $error("read-only zero bit set");
  a_wake_pin_on: assert property (wake_pin |=> gate_en[5]
    && !pcg1_q[`CIG_SYSOFF_BIT])
    else $error("wake pin did not restart system clock");
  a_gate2_rw: assert property (wr_fire && wr_sel == SEL_PCG2
    && strb_q[1:0] == 2'h3 |=> pcg2_q == $past(wd_q))
    else $error("gate register 2 write lost");
  a_gate_reset: assert property (disable iff (1'b0) !aresetn
    |=> pcg1_q == 16'h0000 && pcg2_q == 16'h0000)
    else $error("gate registers not cleared by reset");

  c_valid_idle: cover property (idle_exec && idle_ok && icr_q[0]);
  c_bus_error: cover property (bus_error_flag_set);
  c_periph_stop: cover property (!gate_en[6] ##1 gate_en[6]);
  c_wake_up: cover property (idle_status_reg_q[0] ##1 !idle_status_reg_q[0]);
endmodule

// ### sim/cig_cpu_model.sv
// cpu software model: drains the pipeline, then issues a lone idle
`timescale 1ns/1ps
module cig_cpu_model (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic issue, // one-cycle request from the bench
  output logic idle_exec // one-cycle idle instruction pulse
);
  logic [2:0] nop_q;
  logic busy_q;

  // six no-ops between the config write and the idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'h0;
      nop_q <= 3'h0;
      idle_exec <= 1'h0;
    end else begin
      idle_exec <= 1'h0;
      if (issue) begin
        busy_q <= 1'h1;
        nop_q <= 3'h0;
      end else if (busy_q && nop_q == 3'h5) begin
        busy_q <= 1'h0;
        idle_exec <= 1'h1;
      end else if (busy_q) begin
        nop_q <= nop_q + 3'h1;
      end
    end
  end
endmodule

// ### sim/cpu_idle_and_peripheral_clock_gating_bench.sv
// self-checking bench for the idle and peripheral clock gating block
`timescale 1ns/1ps
`include "cig_params.svh"
module cpu_idle_and_peripheral_clock_gating_bench;
  import cig_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, issue, wake_pin, idle_exec;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, int_pending, cpu_clk_g, data_port_clk_g;
  logic io_port_clk_g, mem_port_clk_g, instr_port_clk_g, sys_clk_g;
  logic [15:0] s_axi_awaddr, s_axi_araddr, int_evt0, int_evt1;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [14:0] periph_clk_g;
  cig_idle_s idle_status;
  int num_errors = 0;
  int checks = 0;

  cig_gating #(.SYNC_STAGES(`CIG_PCG_SYNC)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .idle_exec, .int_evt0, .int_evt1, .wake_pin,
    .int_pending, .idle_status, .cpu_clk_g, .data_port_clk_g,
    .io_port_clk_g, .mem_port_clk_g, .instr_port_clk_g, .periph_clk_g,
    .sys_clk_g);
  cig_cpu_model cpu_u (.aclk, .aresetn, .issue, .idle_exec);

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("CHECK FAILED %s expected answer seen none", nm);
    tally_and_finish();
  endtask

  task automatic wr(input logic [13:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    bit dn;
    dn = 0;
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        dn = 1;
      end
    end
    if (!dn) hang("write");
    @(posedge aclk);
  endtask

  task automatic rd(input logic [13:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    bit dn;
    dn = 0;
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        s_axi_rready <= 1'h0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        if (er == `CIG_RESP_OKAY) chk("rdata", {16'h0, e}, s_axi_rdata);
        dn = 1;
      end
    end
    if (!dn) hang("read");
    @(posedge aclk);
  endtask

  task automatic do_idle;
    issue <= 1'h1;
    @(posedge aclk);
    issue <= 1'h0;
    for (int n = 0; n < 20 && idle_exec !== 1'h1; n++) @(posedge aclk);
    if (idle_exec !== 1'h1) hang("idle");
    @(posedge aclk);
  endtask

  // samples every gated clock in the high phase of aclk
  task automatic gclk(input int cyc, output logic [20:0] v);
    repeat (cyc) @(posedge aclk);
    #6;
    v = {sys_clk_g, cpu_clk_g, data_port_clk_g, io_port_clk_g,
         mem_port_clk_g, instr_port_clk_g, periph_clk_g};
    @(posedge aclk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    logic [13:0] idx [8] = '{`CIG_IDX_ICR, `CIG_IDX_IDLE_STATUS_REG, `CIG_IDX_INT_FLAG_REG_0,
      `CIG_IDX_INT_FLAG_REG_1, `CIG_IDX_INT_ENABLE_REG_0, `CIG_IDX_INT_ENABLE_REG_1, `CIG_IDX_PCG1,
      `CIG_IDX_PCG2};
    logic [20:0] v;
    foreach (idx[i]) rd(idx[i], `CIG_REG_RST, `CIG_RESP_OKAY);
    gclk(1, v);
    chk("clocks after reset", 21'h1FFFFF, v);
    $display("test reset done");
  endtask

  task automatic t_pcg1;
    logic [20:0] v;
    wr(`CIG_IDX_PCG1, 16'hFFFF, `CIG_RESP_OKAY);
    gclk(4, v);
    chk("clocks system off", 21'h000000, v);
    rd(`CIG_IDX_PCG1, 16'hFFDF, `CIG_RESP_OKAY);
    wake_pin <= 1'h1;
    gclk(6, v);
    // bit 7 is a plain r/w bit and gates its clock; only bit 5 stays on
    chk("clocks woken", {6'h3F, 15'h0020}, v);
    rd(`CIG_IDX_PCG1, 16'h7FDF, `CIG_RESP_OKAY);
    wr(`CIG_IDX_PCG1, 16'h0000, `CIG_RESP_OKAY);
    gclk(4, v);
    chk("clocks restarted", 21'h1FFFFF, v);
    $display("test peripheral gating done");
  endtask

  task automatic t_bus;
    wr(`CIG_IDX_PCG2, 16'hA5A5, `CIG_RESP_OKAY);
    rd(`CIG_IDX_PCG2, 16'hA5A5, `CIG_RESP_OKAY);
    wr(`CIG_IDX_IDLE_STATUS_REG, 16'hFFFF, `CIG_RESP_OKAY);
    rd(`CIG_IDX_IDLE_STATUS_REG, 16'h0000, `CIG_RESP_OKAY);
    wr(14'h0100, 16'h1234, `CIG_RESP_SLVERR);
    rd(14'h0100, 16'h0000, `CIG_RESP_SLVERR);
    int_evt0 <= 16'h8001;
    @(posedge aclk);
    int_evt0 <= 16'h0000;
    rd(`CIG_IDX_INT_FLAG_REG_0, 16'h8001, `CIG_RESP_OKAY);
    chk("pending unenabled", 32'h0, {31'h0, int_pending});
    wr(`CIG_IDX_INT_FLAG_REG_0, 16'hFFFF, `CIG_RESP_OKAY);
    rd(`CIG_IDX_INT_FLAG_REG_0, 16'h0000, `CIG_RESP_OKAY);
    $display("test bus map done");
  endtask

  task automatic t_bad_idle;
    logic [15:0] cfg [5] = '{16'h002F, 16'h0080, 16'h005E, 16'h011E,
                             16'h003E};
    foreach (cfg[i]) begin
      wr(`CIG_IDX_ICR, cfg[i], `CIG_RESP_OKAY);
      do_idle();
      rd(`CIG_IDX_IDLE_STATUS_REG, 16'h0000, `CIG_RESP_OKAY);
      rd(`CIG_IDX_INT_FLAG_REG_1, 16'h1 << `CIG_BUS_ERROR_FLAG_BIT, `CIG_RESP_OKAY);
      wr(`CIG_IDX_INT_FLAG_REG_1, 16'hFFFF, `CIG_RESP_OKAY);
      rd(`CIG_IDX_INT_FLAG_REG_1, 16'h0000, `CIG_RESP_OKAY);
    end
    $display("test invalid idle done");
  endtask

  task automatic t_good_idle;
    logic [15:0] cfg [3] = '{16'h01FF, 16'h005F, 16'h0001};
    logic [20:0] v;
    wr(`CIG_IDX_INT_ENABLE_REG_1, 16'h0001, `CIG_RESP_OKAY);
    foreach (cfg[i]) begin
      wr(`CIG_IDX_ICR, cfg[i], `CIG_RESP_OKAY);
      do_idle();
      rd(`CIG_IDX_IDLE_STATUS_REG, cfg[i] & `CIG_IDLE_STATUS_REG_MASK, `CIG_RESP_OKAY);
      chk("idle status", {16'h0, cfg[i] & `CIG_IDLE_STATUS_REG_MASK},
          {16'h0, idle_status});
      gclk(0, v);
      chk("idle clocks", {1'h1, ~cfg[i][0], ~cfg[i][5], ~cfg[i][6],
          ~cfg[i][7], ~cfg[i][8], 15'h7FFF}, v);
      int_evt1 <= 16'h0001;
      @(posedge aclk);
      int_evt1 <= 16'h0000;
      gclk(3, v);
      chk("clocks after wake", 21'h1FFFFF, v);
      chk("status after wake", 32'h0, {16'h0, idle_status});
      chk("wake pending", 32'h1, {31'h0, int_pending});
      wr(`CIG_IDX_INT_FLAG_REG_1, 16'hFFFF, `CIG_RESP_OKAY);
      rd(`CIG_IDX_INT_FLAG_REG_1, 16'h0000, `CIG_RESP_OKAY);
      chk("pending cleared", 32'h0, {31'h0, int_pending});
    end
    $display("test valid idle done");
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    hang("run");
  end

  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, issue, wake_pin} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, int_evt0, int_evt1} = 64'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_pcg1();
    t_bus();
    t_bad_idle();
    t_good_idle();
    tally_and_finish();
  end
endmodule
